/* File: src/fsk_consts.svh */
`ifndef FSK_CONSTS_SVH
`define FSK_CONSTS_SVH

// Byte addresses of the programming port.
`define FSK_ADDR_TW1       6'h04
`define FSK_ADDR_TW2       6'h0A
`define FSK_ADDR_STEP      6'h10
`define FSK_ADDR_RATE      6'h1A
`define FSK_ADDR_CTRL      6'h1F

// Byte counts of the multi-byte registers.
`define FSK_WORD_BYTES     6'h06
`define FSK_RATE_BYTES     6'h03

// Control register field positions.
`define FSK_CTL_CLR_FREQ   7
`define FSK_CTL_CLR_ALL    6
`define FSK_CTL_TRIANGLE   5
`define FSK_CTL_MODE_LSB   0

// Reset values.
`define FSK_CTRL_RESET     8'h00
`define FSK_WORD_RESET     48'h000000000000
`define FSK_RATE_RESET     20'h00000

`endif

/* File: src/fsk_pkg.sv */
package fsk_pkg;

	typedef enum logic [2:0] {
		FSK_MODE_SINGLE = 3'h0,
		FSK_MODE_KEYED  = 3'h1,
		FSK_MODE_RAMPED = 3'h2,
		FSK_MODE_CHIRP  = 3'h3,
		FSK_MODE_PSK    = 3'h4
	} fsk_mode_t;

endpackage

/* File: src/fsk_rate_counter.sv */
`timescale 1ns/10ps
`include "fsk_consts.svh"

module fsk_rate_counter import fsk_pkg::*; #(
	parameter int RATE_W = 20
) (
	// Clock and reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst,
	// Control
	input  wire logic              i_run,
	input  wire logic              i_restart,
	input  wire logic [RATE_W-1:0] i_count,
	// Tick out
	output logic                   o_pulse
);

	logic [RATE_W-1:0] cnt;
	logic [RATE_W:0]   gap;
	logic [RATE_W-1:0] load_q;
	logic [RATE_W-1:0] expect_n;
	logic              seen;
	wire               at_zero = (cnt == '0);

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cnt     <= '0;
			o_pulse <= 1'b0;
		end else if (!i_run || i_restart) begin
			cnt     <= i_count;
			o_pulse <= 1'b0;
		end else if (at_zero) begin
			cnt     <= i_count;
			o_pulse <= 1'b1;
		end else begin
			cnt     <= cnt - 1'b1;
			o_pulse <= 1'b0;
		end
	end

	// Helper state for the spacing check only.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			gap      <= '0;
			load_q   <= '0;
			expect_n <= '0;
			seen     <= 1'b0;
		end else begin
			gap <= o_pulse ? {{RATE_W{1'b0}}, 1'b1} : gap + 1'b1;
			if (i_run && !i_restart && at_zero)
				load_q <= i_count;
			if (o_pulse)
				expect_n <= load_q;
			seen <= (i_run && !i_restart) && (seen || o_pulse);
		end
	end

	chk_pulse_spacing_n: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(o_pulse && seen && i_run && !i_restart) |-> (gap == {1'b0, expect_n} + 1'b1))
		else $error("ramp tick spacing is not N+1 clocks");

endmodule

/* File: src/fsk_ramp_core.sv */
// Behaviour
// - Unramped keying: key low selects first word, high selects second.
// - Word switch is phase continuous after a two-clock key synchroniser and a one-clock output register.
// - Unramped keying otherwise behaves like single-frequency mode.
// - Ramped keying steps through intermediate frequencies, never jumps.
// - Ramp-rate counter is a 20-bit system-clock down-counter pulsing at zero.
// - Any keying input level change outside a triangle sweep starts the ramp-rate counter.
// - Ramp ticks are N+1 clocks apart, N from 1 to 2^20-1.
// - Counter stops at destination; output dwells while key level holds.
// - Each ramp tick adds the 48-bit step word to the accumulator or subtracts it, clamped at the destination.
// - Accumulator adds to or subtracts from start word per key state.
// - Early key toggle reverses the ramp at the same rate and step.
// - Triangle bit in ramped mode sweeps continuously, ignoring the key.
// - Triangle sweep starts at first word if key low, else second.
// - Step writes during a ramp take effect at once; rate writes take effect at the next counter reload.
// - Ramped output stays between first and second word frequencies.
// - Setting accumulator clear makes a one-clock pulse returning the accumulator to the ramp start point.
// - Clear held set re-fires on each update rising edge, restarting the ramp.
// - Clear-all holds both accumulators at zero until released.
// - Three-bit mode field: 001 unramped keying, 010 ramped keying.
`timescale 1ns/10ps
`include "fsk_consts.svh"

module fsk_ramp_core import fsk_pkg::*; #(
	parameter int FW     = 48,
	parameter int RATE_W = 20
) (
	// Clock and reset
	input  wire logic          i_clk_sys,
	input  wire logic          i_rst,
	// Programming port
	input  wire logic [5:0]    i_reg_addr,
	input  wire logic [7:0]    i_reg_wdata,
	input  wire logic          i_reg_wr,
	input  wire logic          i_reg_rd,
	output logic      [7:0]    o_reg_rdata,
	// Pins
	input  wire logic          i_keying_input,
	input  wire logic          i_update,
	// Synthesizer core
	output logic      [FW-1:0] o_ftw,
	output logic      [FW-1:0] o_phase
);

	logic [FW-1:0]     tuning_word_one;
	logic [FW-1:0]     tuning_word_two;
	logic [FW-1:0]     frequency_step_word;
	logic [RATE_W-1:0] ramp_interval_count;
	logic [7:0]        sweep_control;
	logic [2:0]        key_sync;
	logic [2:0]        upd_sync;
	logic              freq_clear_pulse;
	logic [FW-1:0]     frequency_accumulator;
	logic              tri_up;
	logic              tri_prev;
	logic              rate_pulse;

	function automatic logic in_range(input logic [5:0] addr, input logic [5:0] base, input logic [5:0] len);
		in_range = (addr >= base) && (addr < base + len);
	endfunction

	function automatic logic [FW-1:0] put48(input logic [FW-1:0] word, input logic [2:0] idx,
		input logic [7:0] data);
		logic [FW-1:0] w;
		w = word;
		w[(5 - idx) * 8 +: 8] = data;
		put48 = w;
	endfunction

	function automatic logic [7:0] get48(input logic [FW-1:0] word, input logic [2:0] idx);
		get48 = word[(5 - idx) * 8 +: 8];
	endfunction

	// Register decode.
	wire       hit_tw1   = in_range(i_reg_addr, `FSK_ADDR_TW1, `FSK_WORD_BYTES);
	wire       hit_tw2   = in_range(i_reg_addr, `FSK_ADDR_TW2, `FSK_WORD_BYTES);
	wire       hit_step  = in_range(i_reg_addr, `FSK_ADDR_STEP, `FSK_WORD_BYTES);
	wire       hit_rate  = in_range(i_reg_addr, `FSK_ADDR_RATE, `FSK_RATE_BYTES);
	wire       hit_ctrl  = (i_reg_addr == `FSK_ADDR_CTRL);
	wire [2:0] idx_tw1   = 3'(i_reg_addr - `FSK_ADDR_TW1);
	wire [2:0] idx_tw2   = 3'(i_reg_addr - `FSK_ADDR_TW2);
	wire [2:0] idx_step  = 3'(i_reg_addr - `FSK_ADDR_STEP);
	wire [2:0] idx_rate  = 3'(i_reg_addr - `FSK_ADDR_RATE);
	wire [23:0] rate_24  = {4'h0, ramp_interval_count};
	// A rate byte is merged into the 24-bit image, so the unused top nibble falls away cleanly.
	wire [23:0] rate_merged = (idx_rate == 3'h0) ? {i_reg_wdata, rate_24[15:0]} :
	                          (idx_rate == 3'h1) ? {rate_24[23:16], i_reg_wdata, rate_24[7:0]} :
	                          {rate_24[23:8], i_reg_wdata};
	wire [7:0] rd_byte   = hit_tw1  ? get48(tuning_word_one, idx_tw1) :
	                       hit_tw2  ? get48(tuning_word_two, idx_tw2) :
	                       hit_step ? get48(frequency_step_word, idx_step) :
	                       hit_rate ? rate_24[(2 - idx_rate) * 8 +: 8] :
	                       hit_ctrl ? sweep_control : 8'h00;

	// Control fields.
	// Mode field decode.
	wire [2:0] mode_bits = sweep_control[`FSK_CTL_MODE_LSB +: 3];
	wire       keyed_on  = (mode_bits == FSK_MODE_KEYED);
	wire       ramp_on   = (mode_bits == FSK_MODE_RAMPED);
	wire       clr_freq  = sweep_control[`FSK_CTL_CLR_FREQ];
	wire       clr_all   = sweep_control[`FSK_CTL_CLR_ALL];
	wire       tri_on    = ramp_on && sweep_control[`FSK_CTL_TRIANGLE];

	// Pin synchronisers; stage 0 is only read by stage 1.
	wire       key_s     = key_sync[1];
	// A key level change restarts the counter outside a triangle sweep.
	wire       key_edge  = key_sync[1] ^ key_sync[2];
	wire       upd_rise  = upd_sync[1] && !upd_sync[2];
	wire       tri_rise  = tri_on && !tri_prev;

	wire          up       = tri_on ? tri_up : key_s;
	wire [FW-1:0] span     = tuning_word_two - tuning_word_one;
	wire          at_dest  = up ? (frequency_accumulator == span) : (frequency_accumulator == '0);
	// Position moves by at most one step per tick.
	wire [FW:0]   sum      = {1'b0, frequency_accumulator} + {1'b0, frequency_step_word};
	// Clamp the final step at the destination.
	wire [FW-1:0] up_next  = (sum >= {1'b0, span}) ? span : sum[FW-1:0];
	wire [FW-1:0] dn_next  = (frequency_accumulator <= frequency_step_word) ? '0 :
	                         frequency_accumulator - frequency_step_word;
	// Counter idles once the destination is reached.
	wire          rate_run = ramp_on && !clr_all && (tri_on || !at_dest);
	// A key edge must not restart the counter during a triangle sweep.
	wire          rate_restart = (key_edge && !tri_on) || freq_clear_pulse || tri_rise;
	wire          step_now = rate_pulse && rate_run && !rate_restart;
	wire          arrive   = step_now && (up ? (up_next == span) : (dn_next == '0));

	// Clear-all wins over every other accumulator source.
	// Triangle start point follows the key at the rising edge.
	// Clear pulse returns the accumulator to the start point.
	// Reversal keeps the current position and only flips direction.
	wire [FW-1:0] next_accum = clr_all          ? '0 :
	                           tri_rise         ? (key_s ? span : '0) :
	                           freq_clear_pulse ? (up ? '0 : span) :
	                           step_now         ? (up ? up_next : dn_next) :
	                           frequency_accumulator;

	// Output is the first word plus the distance travelled upward.
	// Position stays within zero to span, so output stays in band.
	// Key selects the tuning word in unramped mode.
	// Any other mode falls back to the first word.
	wire [FW-1:0] next_ftw = clr_all  ? '0 :
	                         keyed_on ? (key_s ? tuning_word_two : tuning_word_one) :
	                         ramp_on  ? tuning_word_one + frequency_accumulator :
	                         tuning_word_one;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			tuning_word_one     <= `FSK_WORD_RESET;
			tuning_word_two     <= `FSK_WORD_RESET;
			frequency_step_word <= `FSK_WORD_RESET;
			ramp_interval_count <= `FSK_RATE_RESET;
			sweep_control       <= `FSK_CTRL_RESET;
		end else if (i_reg_wr) begin
			// Step and rate bytes land straight in the live registers.
			if (hit_tw1)
				tuning_word_one <= put48(tuning_word_one, idx_tw1, i_reg_wdata);
			if (hit_tw2)
				tuning_word_two <= put48(tuning_word_two, idx_tw2, i_reg_wdata);
			if (hit_step)
				frequency_step_word <= put48(frequency_step_word, idx_step, i_reg_wdata);
			if (hit_rate)
				ramp_interval_count <= rate_merged[RATE_W-1:0];
			if (hit_ctrl)
				sweep_control <= i_reg_wdata;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			key_sync    <= 3'h0;
			upd_sync    <= 3'h0;
			o_reg_rdata <= 8'h00;
		end else begin
			key_sync    <= {key_sync[1:0], i_keying_input};
			upd_sync    <= {upd_sync[1:0], i_update};
			o_reg_rdata <= i_reg_rd ? rd_byte : o_reg_rdata;
		end
	end

	// One-clock clear on a control write with the bit set.
	// Held bit re-fires on every update rising edge.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst)
			freq_clear_pulse <= 1'b0;
		else
			freq_clear_pulse <= (i_reg_wr && hit_ctrl && i_reg_wdata[`FSK_CTL_CLR_FREQ]) ||
			                    (clr_freq && upd_rise);
	end

	// Direction flips on arrival, so each end dwells one interval.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			frequency_accumulator <= '0;
			tri_up                <= 1'b0;
			tri_prev              <= 1'b0;
		end else begin
			frequency_accumulator <= next_accum;
			tri_prev              <= tri_on;
			if (tri_rise)
				tri_up <= !key_s;
			else if (tri_on && arrive)
				tri_up <= !tri_up;
		end
	end

	// One-clock pipeline; the phase accumulator is never reloaded, so
	// a word change keeps the running phase.
	// Clear-all holds the phase at zero.
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_ftw   <= '0;
			o_phase <= '0;
		end else begin
			o_ftw   <= next_ftw;
			o_phase <= clr_all ? '0 : o_phase + o_ftw;
		end
	end

	fsk_rate_counter #(
		.RATE_W (RATE_W)
	) u_rate (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_run     (rate_run),
		.i_restart (rate_restart),
		.i_count   (ramp_interval_count),
		.o_pulse   (rate_pulse)
	);

	sequence s_keyed_word;
		keyed_on && !clr_all;
	endsequence

	chk_unramped_word_sel: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		s_keyed_word |=> (o_ftw == ($past(key_s) ? $past(tuning_word_two) : $past(tuning_word_one))))
		else $error("unramped word does not follow key");

	chk_ramp_output_sum: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(ramp_on && !clr_all) |=> (o_ftw == $past(tuning_word_one) + $past(frequency_accumulator)))
		else $error("ramped word is not start plus accumulator");

	chk_step_add: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(step_now && up && !clr_all && !sum[FW] && (sum[FW-1:0] < span))
		|=> (frequency_accumulator == $past(frequency_accumulator) + $past(frequency_step_word)))
		else $error("ramp tick did not add the step word");

	chk_clamp_dest: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(step_now && !clr_all && !tri_rise) |=> (frequency_accumulator <= $past(span)))
		else $error("ramp step overshot the destination");

	chk_stop_at_dest: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(ramp_on && !tri_on && at_dest && !rate_restart)[*2] |-> !rate_pulse ##1 !rate_pulse)
		else $error("ramp kept stepping at destination");

	chk_reverse_dir: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(ramp_on && !tri_on && key_edge && !clr_all && !freq_clear_pulse)
		|=> (frequency_accumulator == $past(frequency_accumulator)) && (up == key_s))
		else $error("key toggle did not reverse from current point");

	chk_clear_pulse_one: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(freq_clear_pulse && !clr_all && !tri_rise)
		|=> (frequency_accumulator == ($past(up) ? '0 : $past(span))))
		else $error("clear pulse did not return to start point");

	chk_clear_refire: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(clr_freq && upd_rise && !(i_reg_wr && hit_ctrl)) |=> freq_clear_pulse)
		else $error("held clear did not fire on update edge");

	chk_clear_all_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		clr_all |=> (o_ftw == '0) && (o_phase == '0) && (frequency_accumulator == '0))
		else $error("clear-all did not zero the accumulators");

	chk_triangle_start: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(tri_rise && !clr_all) |=> (tri_up == !$past(key_s)) &&
		(frequency_accumulator == ($past(key_s) ? $past(span) : '0)))
		else $error("triangle sweep started at the wrong end");

	chk_step_bounded: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(step_now && !clr_all) |=> ($past(up) ?
			((frequency_accumulator - $past(frequency_accumulator)) <= $past(frequency_step_word)) :
			(($past(frequency_accumulator) - frequency_accumulator) <= $past(frequency_step_word))))
		else $error("ramp step was larger than the step word");

	chk_no_idle_move: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(ramp_on && !clr_all && !freq_clear_pulse && !tri_rise && !step_now)
		|=> (frequency_accumulator == $past(frequency_accumulator)))
		else $error("accumulator moved without a ramp tick");

	sequence s_band_held;
		(ramp_on && (frequency_accumulator <= span)) ##1 $stable(span);
	endsequence

	chk_ramp_in_band: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		s_band_held |-> (frequency_accumulator <= span))
		else $error("ramp position left the band between the two words");

endmodule

/* File: testbench/fsk_pin_source.sv */
`timescale 1ns/10ps

// The keying source and update pin change asynchronously to the system clock.
// The delay keeps each pin edge away from the clock edge.
module fsk_pin_source #(
	parameter int PIN_DLY = 3
) (
	// Requests from the host side
	input  wire logic i_key_req,
	input  wire logic i_upd_req,
	// Pins
	output logic      o_keying_input,
	output logic      o_update
);
	// Continuous drive, so the pins follow the request level PIN_DLY later and are unknown for the first PIN_DLY.
	assign #PIN_DLY o_keying_input = i_key_req;
	assign #PIN_DLY o_update       = i_upd_req;
endmodule

/* File: testbench/test_fsk_ramp_core.sv */
`timescale 1ns/10ps
`include "fsk_consts.svh"

module test_fsk_ramp_core;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  addr = 6'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  rdata;
	logic        key_req = 1'b0;
	logic        upd_req = 1'b0;
	logic        key_pin;
	logic        upd_pin;
	logic [47:0] ftw;
	logic [47:0] phase;
	logic [47:0] p0;
	int          gap;
	int          n_fail = 0;
	int          n_compared = 0;

	always #5 clk = ~clk;

	fsk_pin_source src_u (
		.i_key_req      (key_req),
		.i_upd_req      (upd_req),
		.o_keying_input (key_pin),
		.o_update       (upd_pin)
	);

	fsk_ramp_core dut_u (
		.i_clk_sys      (clk),
		.i_rst          (rst),
		.i_reg_addr     (addr),
		.i_reg_wdata    (wdata),
		.i_reg_wr       (wr),
		.i_reg_rd       (rd),
		.o_reg_rdata    (rdata),
		.i_keying_input (key_pin),
		.i_update       (upd_pin),
		.o_ftw          (ftw),
		.o_phase        (phase)
	);

	task end_of_test;
		if (n_fail == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task chk(input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task wr8(input logic [5:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask

	task rd8(input logic [5:0] a, input logic [7:0] exp);
		addr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		chk({40'h0, rdata}, {40'h0, exp});
		cyc(1);
	endtask

	task w48(input logic [5:0] b, input logic [47:0] v);
		for (int i = 0; i < 6; i++) wr8(b + 6'(i), v[47 - 8 * i -: 8]);
	endtask

	// Waits, under a bound, for the tuning word to move and compares the new value.
	task chg(input logic [47:0] exp);
		logic [47:0] prev;
		prev = ftw;
		gap = 0;
		while (ftw === prev && gap < 200) begin
			cyc(1);
			gap++;
		end
		chk(ftw, exp);
	endtask

	initial begin
		#100000;
		n_fail++;
		end_of_test;
	end

	initial begin
		cyc(10);
		rst = 1'b0;
		chk(ftw, 48'h0);
		chk(phase, 48'h0);
		rd8(`FSK_ADDR_CTRL, 8'h00);
		// Host loads the lower frequency first.
		w48(`FSK_ADDR_TW1, 48'd100);
		w48(`FSK_ADDR_TW2, 48'd130);
		w48(`FSK_ADDR_STEP, 48'd10);
		wr8(`FSK_ADDR_RATE, 8'hF0);
		rd8(`FSK_ADDR_RATE, 8'h00);
		wr8(`FSK_ADDR_RATE, 8'h00);
		wr8(6'h1C, 8'h04);
		rd8(6'h0F, 8'h82);
		rd8(6'h3F, 8'h00);
		key_req = 1'b1;
		cyc(6);
		chk(ftw, 48'd100);
		wr8(`FSK_ADDR_CTRL, 8'h03);
		chk(ftw, 48'd100);
		wr8(`FSK_ADDR_CTRL, 8'h01);
		rd8(`FSK_ADDR_CTRL, 8'h01);
		cyc(3);
		chk(ftw, 48'd130);
		p0 = phase;
		cyc(1);
		chk(phase - p0, 48'd130);
		key_req = 1'b0;
		cyc(6);
		chk(ftw, 48'd100);
		wr8(`FSK_ADDR_CTRL, 8'h02);
		wr8(`FSK_ADDR_CTRL, 8'h82);
		wr8(`FSK_ADDR_CTRL, 8'h02);
		cyc(40);
		chk(ftw, 48'd100);
		key_req = 1'b1;
		chg(48'd110);
		chg(48'd120);
		chk(48'(gap), 48'd5);
		chg(48'd130);
		chk(48'(gap), 48'd5);
		cyc(30);
		chk(ftw, 48'd130);
		key_req = 1'b0;
		chg(48'd120);
		key_req = 1'b1;
		chg(48'd130);
		key_req = 1'b0;
		chg(48'd120);
		chg(48'd110);
		chg(48'd100);
		wr8(6'h15, 8'h0C);
		key_req = 1'b1;
		chg(48'd112);
		chg(48'd124);
		chg(48'd130);
		key_req = 1'b0;
		chg(48'd118);
		wr8(6'h15, 8'h03);
		chg(48'd115);
		wr8(6'h15, 8'h0F);
		chg(48'd100);
		wr8(6'h15, 8'h0A);
		wr8(`FSK_ADDR_CTRL, 8'h22);
		chg(48'd110);
		chg(48'd120);
		key_req = 1'b1;
		chg(48'd130);
		chk(48'(gap), 48'd5);
		chg(48'd120);
		chg(48'd110);
		chg(48'd100);
		chg(48'd110);
		wr8(`FSK_ADDR_CTRL, 8'h02);
		cyc(40);
		chk(ftw, 48'd130);
		wr8(`FSK_ADDR_CTRL, 8'h82);
		chg(48'd100);
		chg(48'd110);
		cyc(30);
		chk(ftw, 48'd130);
		upd_req = 1'b1;
		chg(48'd100);
		chg(48'd110);
		upd_req = 1'b0;
		wr8(`FSK_ADDR_CTRL, 8'h42);
		cyc(4);
		chk(ftw, 48'h0);
		cyc(4);
		chk(phase, 48'h0);
		end_of_test;
	end
endmodule
